// File: rtl/remote_limit_compare_regs.sv
// Remote limit registers, critical lock, shutdown and alert generation.
// Assumes the serial bus engine, configuration registers and converter all
// run on clk; their strobes arrive as single-cycle pulses.
`timescale 1ns/1ps
`include "remote_limit_regs.svh"
module remote_limit_compare_regs
   import remote_limit_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register access from the serial bus engine
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Configuration bits held elsewhere
   input wire logic limit_override,
   input wire logic unsigned_format_select,
   // Conversion results
   input wire logic conv_valid,
   input wire logic [10:0] conv_temp,
   // Alarm status read strobe
   input wire logic status_read,
   // Status and pins
   output logic remote_critical_flag,
   output logic remote_low_flag,
   output logic critical_limit_locked,
   output logic [1:0] filter_select,
   output logic filter_enable,
   output logic filter_maximum,
   output logic comparator_mode_select,
   output logic critical_shutdown_n,
   output logic alert_n
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   limit_state_s s_q;
   limit_state_s s_d;

   logic above_crit;
   logic below_low;
   logic below_release;
   logic wr_low_upper;
   logic wr_low_lower;
   logic wr_crit;
   logic wr_hyst;
   logic wr_filt;
   logic [7:0] rd_mux;

   // ----------------------------------------
   // Comparison of the incoming result
   // ----------------------------------------
   remote_compare i_remote_compare (
      .temp(conv_temp),
      .low_limit({s_q.low_upper, s_q.low_frac}),
      .crit_limit(s_q.crit),
      .hyst(s_q.hyst),
      .unsigned_format_select(unsigned_format_select),
      .above_crit(above_crit),
      .below_low(below_low),
      .below_release(below_release)
   );

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   // Low limit upper byte answers at both of its addresses
   assign wr_low_upper = reg_wr && ((reg_addr == `LOW_UPPER_ADDR) ||
                         (reg_addr == `LOW_UPPER_ALT_ADDR));
   assign wr_low_lower = reg_wr && (reg_addr == `LOW_LOWER_ADDR);
   assign wr_crit = reg_wr && (reg_addr == `CRIT_LIMIT_ADDR);
   assign wr_hyst = reg_wr && (reg_addr == `CRIT_HYST_ADDR);
   assign wr_filt = reg_wr && (reg_addr == `FILTER_CTRL_ADDR);

   // Read multiplexer; unmapped addresses return zero
   always_comb begin
      unique case (reg_addr)
         `LOW_UPPER_ADDR,
         `LOW_UPPER_ALT_ADDR: begin
            rd_mux = s_q.low_upper;
         end
         `LOW_LOWER_ADDR: begin
            rd_mux = {s_q.low_frac, 5'b0_0000};
         end
         `CRIT_LIMIT_ADDR: begin
            rd_mux = s_q.crit;
         end
         `CRIT_HYST_ADDR: begin
            rd_mux = {1'b0, s_q.hyst};
         end
         `FILTER_CTRL_ADDR: begin
            // Bits 7:6 and 5:3 are not stored
            rd_mux = {5'b0_0000, s_q.filt, s_q.cmp_mode};
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;

      // Register writes
      if (wr_low_upper) begin
         s_d.low_upper = reg_wdata;
      end
      if (wr_low_lower) begin
         // Low bits dropped, so they can never read back nonzero
         s_d.low_frac = reg_wdata[`LOW_FRAC_HI:`LOW_FRAC_LO];
      end
      // A locked limit ignores writes until the next reset
      if (wr_crit && !s_q.locked) begin
         s_d.crit = reg_wdata;
         if (!limit_override) begin
            s_d.locked = 1'b1;
         end
      end
      if (wr_hyst) begin
         s_d.hyst = reg_wdata[`HYST_HI:0];
      end
      if (wr_filt) begin
         // Bits 7:6 are expected zero and are not kept
         s_d.filt = reg_wdata[`FILTER_SEL_HI:`FILTER_SEL_LO];
         s_d.cmp_mode = reg_wdata[`CMP_MODE_BIT];
      end

      // Read data held until the next read
      if (reg_rd) begin
         s_d.rdata = rd_mux;
      end

      // Status read clears flags whose condition has gone
      if (status_read && !s_q.cond_crit) begin
         s_d.crit_flag = 1'b0;
      end
      if (status_read && !s_q.cond_low) begin
         s_d.low_flag = 1'b0;
      end

      // Conversion result; set wins over a same-cycle clear
      if (conv_valid) begin
         s_d.cond_crit = above_crit;
         s_d.cond_low = below_low;
         if (above_crit) begin
            s_d.crit_flag = 1'b1;
            s_d.critical_shutdown_output = 1'b1;
         end else if (below_release) begin
            s_d.critical_shutdown_output = 1'b0;
         end
         if (below_low) begin
            s_d.low_flag = 1'b1;
         end
      end

      // Alert: follows the live condition or the latched flags
      if (s_d.cmp_mode) begin
         s_d.alert = s_d.cond_crit || s_d.cond_low;
      end else begin
         s_d.alert = s_d.crit_flag || s_d.low_flag;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{
            low_upper: `LOW_UPPER_RST,
            low_frac: `LOW_FRAC_RST,
            crit: `CRIT_LIMIT_RST,
            hyst: `CRIT_HYST_RST,
            filt: `FILTER_SEL_RST,
            cmp_mode: `CMP_MODE_RST,
            locked: 1'b0,
            critical_shutdown_output: 1'b0,
            cond_crit: 1'b0,
            cond_low: 1'b0,
            crit_flag: 1'b0,
            low_flag: 1'b0,
            alert: 1'b0,
            rdata: 8'h00
         };
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign reg_rdata = s_q.rdata;
   assign remote_critical_flag = s_q.crit_flag;
   assign remote_low_flag = s_q.low_flag;
   assign critical_limit_locked = s_q.locked;
   assign filter_select = s_q.filt;
   // Codes 01 and 10 give the same minimal level
   assign filter_enable = (s_q.filt != `FILTER_OFF);
   assign filter_maximum = (s_q.filt == `FILTER_MAX);
   assign comparator_mode_select = s_q.cmp_mode;
   assign critical_shutdown_n = ~s_q.critical_shutdown_output;
   assign alert_n = ~s_q.alert;

endmodule

// File: pkg/remote_limit_regs.svh
// Register offsets, field positions, reset values for the remote limit block.
// Assumes nothing of the includer's scope; it holds only macros.
`ifndef REMOTE_LIMIT_REGS_SVH
`define REMOTE_LIMIT_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LOW_UPPER_ADDR 8'h08
`define LOW_UPPER_ALT_ADDR 8'h0E
`define LOW_LOWER_ADDR 8'h14
`define CRIT_LIMIT_ADDR 8'h19
`define CRIT_HYST_ADDR 8'h21
`define FILTER_CTRL_ADDR 8'hBF

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LOW_UPPER_RST 8'h00
`define LOW_FRAC_RST 3'h0
`define CRIT_LIMIT_RST 8'h6E
`define CRIT_HYST_RST 7'h0A
`define FILTER_SEL_RST 2'h0
`define CMP_MODE_RST 1'h0

// ----------------------------------------
// Field positions and filter codes
// ----------------------------------------
`define LOW_FRAC_HI 7
`define LOW_FRAC_LO 5
`define HYST_HI 6
`define FILTER_SEL_HI 2
`define FILTER_SEL_LO 1
`define CMP_MODE_BIT 0
`define FILTER_OFF 2'h0
`define FILTER_MAX 2'h3

`endif

// File: pkg/remote_limit_pkg.sv
// Types shared by the remote limit block.
// Assumes nothing of its surroundings.
package remote_limit_pkg;

   // ----------------------------------------
   // Whole state of the limit block
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] low_upper;
      logic [2:0] low_frac;
      logic [7:0] crit;
      logic [6:0] hyst;
      logic [1:0] filt;
      logic cmp_mode;
      logic locked;
      logic critical_shutdown_output;
      logic cond_crit;
      logic cond_low;
      logic crit_flag;
      logic low_flag;
      logic alert;
      logic [7:0] rdata;
   } limit_state_s;

endpackage

// File: rtl/remote_compare.sv
// Combinational comparison of one conversion result against the limits.
// Assumes temperatures in 8.3 fixed point, integer byte over three fractions.
`timescale 1ns/1ps
module remote_compare (
   // Conversion and limits
   input wire logic [10:0] temp,
   input wire logic [10:0] low_limit,
   input wire logic [7:0] crit_limit,
   input wire logic [6:0] hyst,
   input wire logic unsigned_format_select,
   // Results
   output logic above_crit,
   output logic below_low,
   output logic below_release
);

   logic [12:0] temp_x;
   logic [12:0] crit_x;
   logic [12:0] low_x;
   logic [12:0] release_x;

   // Thirteen bits so limit minus hysteresis never wraps
   always_comb begin
      if (unsigned_format_select) begin
         temp_x = {2'b00, temp};
         crit_x = {2'b00, crit_limit, 3'b000};
      end else begin
         temp_x = {{2{temp[10]}}, temp};
         crit_x = {{2{crit_limit[7]}}, crit_limit, 3'b000};
      end
      low_x = {{2{low_limit[10]}}, low_limit};
      release_x = crit_x - {3'b000, hyst, 3'b000};
      above_crit = $signed(temp_x) > $signed(crit_x);
      below_low = $signed(temp_x) < $signed(low_x);
      below_release = $signed(temp_x) < $signed(release_x);
   end

endmodule

// File: dv/smb_host.sv
// Host model: register strobes of the limit block.
// Assumes requests launch at falling clk edges.
`timescale 1ns/1ps
module smb_host (
   // Clock
   input wire logic clk,
   // Register port
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   // Idle lines
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // Released lines show inverted values, never stale ones
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = (a == 8'hbf) ? (d & 8'h3f) : d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~reg_wdata;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      @(negedge clk);
      q = reg_rdata;
   endtask
endmodule

// File: dv/remote_limit_monitor.sv
// Checker for the limit block ports.
// Assumes one clk domain, async active-low reset.
`timescale 1ns/1ps
module remote_limit_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic limit_override,
   input wire logic conv_valid,
   // Status and pins
   input wire logic remote_critical_flag,
   input wire logic remote_low_flag,
   input wire logic critical_limit_locked,
   input wire logic [1:0] filter_select,
   input wire logic filter_enable,
   input wire logic filter_maximum,
   input wire logic critical_shutdown_n,
   input wire logic alert_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_low_pad:
      assert property (reg_rd && reg_addr == 8'h14 |=> reg_rdata[4:0] == 0)
      else $error("low limit pad bits not zero");
   a_hyst_top:
      assert property (reg_rd && reg_addr == 8'h21 |=> !reg_rdata[7])
      else $error("hysteresis bit 7 not zero");
   a_filt_pad:
      assert property (reg_rd && reg_addr == 8'hbf |=> reg_rdata[7:3] == 0)
      else $error("filter register pad not zero");
   a_lock_sets:
      assert property (reg_wr && reg_addr == 8'h19 && !limit_override
         |=> critical_limit_locked) else $error("limit did not lock");
   a_lock_holds:
      assert property (critical_limit_locked |=> critical_limit_locked)
      else $error("lock dropped without reset");
   a_filter_on:
      assert property (filter_enable == (filter_select != 2'b00))
      else $error("filter enable decode wrong");
   a_filter_max:
      assert property (filter_maximum == (filter_select == 2'b11))
      else $error("filter maximum decode wrong");
   a_crit_trip:
      assert property ($rose(remote_critical_flag) |->
         !critical_shutdown_n && !alert_n) else $error("critical not driven");
   a_low_alert:
      assert property ($rose(remote_low_flag) |-> !alert_n)
      else $error("low alarm without alert");
   a_shut_conv:
      assert property (!$stable(critical_shutdown_n) |-> $past(conv_valid))
      else $error("shutdown moved without conversion");
endmodule

bind remote_limit_compare_regs
   remote_limit_monitor i_remote_limit_monitor (.*);

// File: dv/test_remote_limit_compare_regs.sv
// Self-checking bench for the remote limit block.
// Assumes smb_host and the bound checker are compiled.
`timescale 1ns/1ps
module test_remote_limit_compare_regs;
   logic clk, rst_n, reg_wr, reg_rd, limit_override, status_read;
   logic unsigned_format_select, conv_valid;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
   logic [10:0] conv_temp;
   logic remote_critical_flag, remote_low_flag, critical_limit_locked;
   logic [1:0] filter_select;
   logic filter_enable, filter_maximum, comparator_mode_select;
   logic critical_shutdown_n, alert_n;
   int err_total, comparisons;
   remote_limit_compare_regs i_remote_limit_compare_regs (.*);
   smb_host i_smb_host (.*);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic rdchk(logic [7:0] a, logic [7:0] e);
      i_smb_host.rd(a, q);
      chk($sformatf("reg %h", a), e, q);
   endtask
   // Conversion pulse; outputs settle one cycle later
   task automatic conv(logic [7:0] t);
      @(negedge clk);
      conv_temp = {t, 3'h0};
      conv_valid = 1'b1;
      @(negedge clk);
      conv_valid = 1'b0;
      conv_temp = ~conv_temp;
   endtask
   // Alarm status read pulse
   task automatic stat();
      @(negedge clk);
      status_read = 1'b1;
      @(negedge clk);
      status_read = 1'b0;
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic t_reset();
      logic [7:0] a[6] = '{8'h08, 8'h0e, 8'h14, 8'h19, 8'h21, 8'hbf};
      logic [7:0] e[6] = '{8'h00, 8'h00, 8'h00, 8'h6e, 8'h0a, 8'h00};
      for (int i = 0; i < 6; i++) begin
         rdchk(a[i], e[i]);
      end
      $display("t_reset done");
   endtask
   task automatic t_regs();
      i_smb_host.wr(8'h0e, 8'ha5);
      rdchk(8'h08, 8'ha5);
      i_smb_host.wr(8'h14, 8'hff);
      rdchk(8'h14, 8'he0);
      i_smb_host.wr(8'h21, 8'hff);
      rdchk(8'h21, 8'h7f);
      i_smb_host.wr(8'h21, 8'h0a);
      i_smb_host.wr(8'h7f, 8'h55);
      rdchk(8'h7f, 8'h00);
      i_smb_host.wr(8'h08, 8'h14);
      i_smb_host.wr(8'h14, 8'h00);
      $display("t_regs done");
   endtask
   task automatic t_filter();
      for (int c = 0; c < 4; c++) begin
         i_smb_host.wr(8'hbf, 8'(c * 2) | 8'h39);
         rdchk(8'hbf, 8'(c * 2) | 8'h01);
         chk("filt_en", 8'(c != 0), 8'(filter_enable));
         chk("filt_max", 8'(c == 3), 8'(filter_maximum));
         chk("filt_sel", 8'(c), 8'(filter_select));
         chk("cmp_mode", 8'h01, 8'(comparator_mode_select));
      end
      i_smb_host.wr(8'hbf, 8'h00);
      $display("t_filter done");
   endtask
   // Limit 100, hysteresis 10, low 20 throughout
   task automatic critical_limit();
      i_smb_host.wr(8'h19, 8'h64);
      chk("locked", 8'h00, 8'(critical_limit_locked));
      conv(8'h65);
      chk("shut", 8'h00, 8'(critical_shutdown_n));
      chk("crit", 8'h01, 8'(remote_critical_flag));
      stat();
      chk("crit_hold", 8'h01, 8'(remote_critical_flag));
      conv(8'h5a);
      chk("shut", 8'h00, 8'(critical_shutdown_n));
      conv(8'h59);
      chk("shut", 8'h01, 8'(critical_shutdown_n));
      stat();
      chk("crit_clr", 8'h00, 8'(remote_critical_flag));
      chk("alert", 8'h01, 8'(alert_n));
      conv(8'hf0);
      chk("crit", 8'h00, 8'(remote_critical_flag));
      chk("low", 8'h01, 8'(remote_low_flag));
      i_smb_host.wr(8'hbf, 8'h01);
      conv(8'h20);
      chk("alert", 8'h01, 8'(alert_n));
      stat();
      chk("low_clr", 8'h00, 8'(remote_low_flag));
      conv(8'hf0);
      chk("alert", 8'h00, 8'(alert_n));
      i_smb_host.wr(8'hbf, 8'h00);
      unsigned_format_select = 1'b1;
      conv(8'hf0);
      chk("crit", 8'h01, 8'(remote_critical_flag));
      $display("critical_limit done");
   endtask
   task automatic t_lock();
      limit_override = 1'b0;
      i_smb_host.wr(8'h19, 8'h50);
      chk("locked", 8'h01, 8'(critical_limit_locked));
      i_smb_host.wr(8'h19, 8'h40);
      rdchk(8'h19, 8'h50);
      @(negedge clk);
      rst_n = 1'b0;
      @(negedge clk);
      rst_n = 1'b1;
      rdchk(8'h19, 8'h6e);
      chk("unlocked", 8'h00, 8'(critical_limit_locked));
      $display("t_lock done");
   endtask
   // Watchdog, far beyond the 120 or so cycles needed
   initial begin
      #200000;
      err_total++;
      test_done();
   end
   initial begin
      rst_n = 1'b0;
      limit_override = 1'b1;
      unsigned_format_select = 1'b0;
      conv_valid = 1'b0;
      conv_temp = 11'h000;
      status_read = 1'b0;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      t_regs();
      t_filter();
      critical_limit();
      t_lock();
      test_done();
   end
endmodule
